// file: fwec_pkg.sv
// Package: register map, field positions, reset values and enumerations of the flash sequencer
package fwec_pkg;

   // ==========================================================
   // Register byte offsets
   localparam logic [11:0] OFS_READ_CONTROL = 12'h0004;
   localparam logic [11:0] OFS_READ_DATA_CONTROL = 12'h0008;
   localparam logic [11:0] OFS_WRITE_CONTROL = 12'h000c;
   localparam logic [11:0] OFS_WRITE_COMMAND = 12'h0010;
   localparam logic [11:0] OFS_TARGET_ADDRESS_BUFFER = 12'h0014;
   localparam logic [11:0] OFS_PROGRAM_WORD_BUFFER = 12'h0018;
   localparam logic [11:0] OFS_CONTROLLER_STATUS = 12'h001c;
   localparam logic [11:0] OFS_CONFIG_KEY = 12'h003c;
   localparam logic [11:0] OFS_MASS_ERASE_GUARD = 12'h0040;

   // ==========================================================
   // Field positions
   localparam int READ_MODE_LSB = 20;
   localparam int READ_OUT_BUFFER_ON_BIT = 12;
   localparam int CACHE_AUTO_INVAL_OFF_BIT = 1;
   localparam int PAGES_TO_ERASE_LSB = 16;
   localparam int LOW_CURRENT_PROGRAM_BIT = 3;
   localparam int ERASE_STOP_ON_IRQ_BIT = 1;
   localparam int PROGRAM_ERASE_ENABLE_BIT = 0;
   localparam int RESET_WORD_BUFFER_CMD_BIT = 12;
   localparam int MASS_ERASE_CMD_BIT = 8;
   localparam int ERASE_STOP_CMD_BIT = 5;
   localparam int MULTI_PAGE_ERASE_CMD_BIT = 4;
   localparam int PROGRAM_STOP_CMD_BIT = 2;
   localparam int SINGLE_PAGE_ERASE_CMD_BIT = 1;
   localparam int MASS_ERASE_GUARD_BIT = 0;
   localparam int ST_FAIL_COUNT_LSB = 28;
   localparam int ST_WRITE_READY_BIT = 27;
   localparam int ST_ARRAY_POWERED_BIT = 24;
   localparam int ST_CONFIG_LOCKED_BIT = 16;
   localparam int ST_RANGE_SKIPPED_BIT = 7;
   localparam int ST_TIMEOUT_BIT = 6;
   localparam int ST_PENDING_BIT = 5;
   localparam int ST_ERASE_STOPPED_BIT = 4;
   localparam int ST_WORD_FREE_BIT = 3;
   localparam int ST_BAD_ADDRESS_BIT = 2;
   localparam int ST_REFUSED_BIT = 1;
   localparam int ST_BUSY_BIT = 0;

   // ==========================================================
   // Reset values and codes
   localparam logic [1:0] READ_MODE_RESET = 2'h2;
   localparam logic READ_OUT_BUFFER_ON_RESET = 1'b1;
   localparam logic MASS_ERASE_GUARD_RESET = 1'b1;
   localparam logic WRITE_READY_RESET = 1'b1;
   localparam logic WORD_FREE_RESET = 1'b1;
   localparam logic [15:0] CONFIG_UNLOCK_CODE = 16'h1b71;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
   // Highest mapped flash byte address; plain default
   localparam logic [31:0] FLASH_ADDR_LIMIT = 32'h000f_ffff;

   // ==========================================================
   // Sequencer states and operation kinds
   typedef enum logic [1:0] {FS_IDLE, FS_PEND, FS_RUN} fwec_state_t;
   typedef enum logic [2:0] {
      OP_NONE, OP_PROGRAM, OP_PAGE_ERASE, OP_RANGE_ERASE, OP_MASS_ERASE
   } fwec_op_t;

endpackage : fwec_pkg

// file: fwec_fail_count.sv
// Saturating four-bit event counter for failed power-up pattern checks
`timescale 1ns/100ps
module fwec_fail_count
   import fwec_pkg::*;
(
   input wire logic core_clk, // Bus clock
   input wire logic sys_rst, // Synchronous reset, active high
   input wire logic bump, // One-cycle pulse per failed check
   output logic [3:0] count // Failures since reset
);

   // ==========================================================
   // State
   typedef struct packed {
      logic [3:0] cnt; // Failure tally
   } fwec_cnt_t;

   fwec_cnt_t cnt_reg; // Registered state
   fwec_cnt_t cnt_next; // Next state

   // Counts up and sticks at fifteen so wraparound never hides failures
   always_comb begin
      cnt_next = cnt_reg;
      if (bump && (cnt_reg.cnt != 4'hf)) begin
         cnt_next.cnt = cnt_reg.cnt + 4'h1;
      end
   end

   // Registers the state
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   assign count = cnt_reg.cnt;

endmodule : fwec_fail_count

// file: fwec_ctrl.sv
// Flash write and erase controller: register file, command decode and sequencer
//
// Contract
// - Read mode selects zero to three wait states
// - Bit 12 routes reads through output buffer
// - Invalidate-off bit suppresses cache invalidate
// - Range count sets pages for range erase
// - Low-current bit selects slower programming mode
// - Erase-stop-on-irq lets interrupts end page erase
// - Write and erase need enable bit set; mass erase does not check it
// - Word buffer reset sets free and DMA
// - Mass erase refused while guard set, except engine
// - Erase stop command ends running erase
// - Range erase starts at buffered address
// - Program stop command ends running write
// - Page erase erases page at buffered address
// - Full 32-bit target address kept, MSB used
// - Program word taken whole, no byte mask
// - Status 31:28 counts pattern check failures
// - Status 27 shows array ready, resets one
// - Status 24 shows array powered
// - Status 16 shows configuration lock state
// - Status 7 flags range erase skipped pages
// - Status 6 flags timeout, cleared by write
// - Status 5 pending; new commands then ignored
// - Word free sets when programming completes, clears on write
// - Status 0 busy; start commands then ignored
// - Key 7025 unlocks control registers, else locks
// - Guard resets one; host sets, root clears
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/100ps
module fwec_ctrl
   import fwec_pkg::*;
(
   input wire logic core_clk, // Bus clock, 40 MHz
   input wire logic sys_rst, // Synchronous reset, active high
   input wire logic [11:0] avs_address, // Byte address
   input wire logic avs_read, // Read request
   input wire logic avs_write, // Write request
   input wire logic [31:0] avs_writedata, // Write data
   output logic [31:0] avs_readdata, // Read data
   output logic avs_waitrequest, // Stall while high
   input wire logic flash_op_done, // Array finished current operation
   input wire logic flash_write_timeout, // Write ended by buffer timeout
   input wire logic flash_range_skipped, // Range erase skipped a locked page
   input wire logic flash_pattern_fail, // Power-up pattern check failed
   input wire logic flash_powered, // Array supply is on
   input wire logic flash_write_ready, // Power-up sequence finished
   input wire logic cpu_irq, // Processor interrupt pending
   input wire logic se_mass_erase, // Security engine mass erase request
   input wire logic root_access, // Current bus master is root or debug
   output logic flash_op_start, // Start pulse for an array operation
   output logic [2:0] flash_op_kind, // Kind of operation
   output logic [31:0] flash_op_addr, // Target address
   output logic [31:0] flash_op_data, // Word to program
   output logic [7:0] flash_op_pages, // Pages for range erase
   output logic flash_op_abort, // Abort pulse for running operation
   output logic flash_low_current, // Reduced-current programming
   output logic [1:0] flash_wait_states, // Read wait states
   output logic flash_out_buf_en, // Read data output buffer enable
   output logic cache_invalidate, // Instruction cache invalidate pulse
   output logic dma_req // Word buffer may be refilled
);

   // ==========================================================
   // State
   typedef struct packed {
      logic [31:0] rdata; // Bus read data
      logic wait_n; // Low while answering
      logic [1:0] read_mode; // Wait-state selection
      logic out_buf_on; // Read output buffer
      logic inval_off; // Cache auto invalidate off
      logic [7:0] pages; // Range count
      logic low_current; // Low-current programming
      logic erase_irq_stop; // Erase stop on interrupt
      logic wr_enable; // Program and erase enable
      logic [31:0] addr; // Target address
      logic [31:0] word; // Program word
      logic word_loaded; // Word waiting to be programmed
      logic word_free; // Word buffer free
      logic locked; // Control registers locked
      logic guard; // Mass erase guard
      logic write_ready; // Array ready for commands
      logic powered; // Array powered
      logic range_skipped; // Range erase skipped pages
      logic timeout; // Write timeout
      logic erase_stopped; // Erase aborted by interrupt
      logic bad_addr; // Unmapped address loaded
      logic refused; // Last command refused
      fwec_state_t state; // Sequencer state
      fwec_op_t op; // Operation in flight
      logic op_start; // Start pulse
      logic op_abort; // Abort pulse
      logic inval; // Cache invalidate pulse
   } fwec_regs_t;

   fwec_regs_t st_reg; // Registered state
   fwec_regs_t st_next; // Next state
   logic [3:0] fail_count; // Pattern failure tally
   logic bus_take; // Request accepted this cycle
   logic wr_hit; // Accepted write
   logic [31:0] status_word; // Assembled status
   logic idle_free; // No command pending or running
   fwec_op_t new_op; // Command requested this cycle

   // ==========================================================
   // Failure counter
   fwec_fail_count u_fail_count (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .bump(flash_pattern_fail),
      .count(fail_count)
   );

   // ==========================================================
   // Status word
   // Gathers live flags into the read-only status layout
   always_comb begin
      status_word = ZERO_WORD;
      status_word[ST_FAIL_COUNT_LSB +: 4] = fail_count;
      status_word[ST_WRITE_READY_BIT] = st_reg.write_ready;
      status_word[ST_ARRAY_POWERED_BIT] = st_reg.powered;
      status_word[ST_CONFIG_LOCKED_BIT] = st_reg.locked;
      status_word[ST_RANGE_SKIPPED_BIT] = st_reg.range_skipped;
      status_word[ST_TIMEOUT_BIT] = st_reg.timeout;
      status_word[ST_PENDING_BIT] = (st_reg.state == FS_PEND);
      status_word[ST_ERASE_STOPPED_BIT] = st_reg.erase_stopped;
      status_word[ST_WORD_FREE_BIT] = st_reg.word_free;
      status_word[ST_BAD_ADDRESS_BIT] = st_reg.bad_addr;
      status_word[ST_REFUSED_BIT] = st_reg.refused;
      status_word[ST_BUSY_BIT] = (st_reg.state == FS_RUN);
   end

   assign bus_take = (avs_read || avs_write) && st_reg.wait_n;
   assign wr_hit = bus_take && avs_write;
   assign idle_free = (st_reg.state == FS_IDLE);

   // ==========================================================
   // Next state
   // Bus slave, register writes, command decode and sequencer in one pass
   always_comb begin
      st_next = st_reg;
      new_op = OP_NONE;
      // Pulses last a single cycle
      st_next.op_start = 1'b0;
      st_next.op_abort = 1'b0;
      st_next.inval = 1'b0;
      st_next.write_ready = flash_write_ready;
      st_next.powered = flash_powered;

      // Bus handshake: one wait cycle, then answer for one cycle
      if (bus_take) begin
         st_next.wait_n = 1'b0;
      end else begin
         st_next.wait_n = 1'b1;
      end

      // Register reads; unmapped and command addresses read zero
      if (bus_take && avs_read) begin
         if (avs_address == OFS_READ_CONTROL) begin
            st_next.rdata = ZERO_WORD;
            st_next.rdata[READ_MODE_LSB +: 2] = st_reg.read_mode;
         end else if (avs_address == OFS_READ_DATA_CONTROL) begin
            st_next.rdata = ZERO_WORD;
            st_next.rdata[READ_OUT_BUFFER_ON_BIT] = st_reg.out_buf_on;
            st_next.rdata[CACHE_AUTO_INVAL_OFF_BIT] = st_reg.inval_off;
         end else if (avs_address == OFS_WRITE_CONTROL) begin
            st_next.rdata = ZERO_WORD;
            st_next.rdata[PAGES_TO_ERASE_LSB +: 8] = st_reg.pages;
            st_next.rdata[LOW_CURRENT_PROGRAM_BIT] = st_reg.low_current;
            st_next.rdata[ERASE_STOP_ON_IRQ_BIT] = st_reg.erase_irq_stop;
            st_next.rdata[PROGRAM_ERASE_ENABLE_BIT] = st_reg.wr_enable;
         end else if (avs_address == OFS_TARGET_ADDRESS_BUFFER) begin
            st_next.rdata = st_reg.addr;
         end else if (avs_address == OFS_PROGRAM_WORD_BUFFER) begin
            st_next.rdata = st_reg.word;
         end else if (avs_address == OFS_CONTROLLER_STATUS) begin
            st_next.rdata = status_word;
         end else if (avs_address == OFS_CONFIG_KEY) begin
            st_next.rdata = ZERO_WORD;
            st_next.rdata[0] = st_reg.locked;
         end else if (avs_address == OFS_MASS_ERASE_GUARD) begin
            st_next.rdata = ZERO_WORD;
            st_next.rdata[MASS_ERASE_GUARD_BIT] = st_reg.guard;
         end else begin
            st_next.rdata = ZERO_WORD;
         end
      end

      // Register writes; control registers only while unlocked
      if (wr_hit) begin
         if ((avs_address == OFS_READ_CONTROL) && !st_reg.locked) begin
            st_next.read_mode = avs_writedata[READ_MODE_LSB +: 2];
         end else if ((avs_address == OFS_READ_DATA_CONTROL) && !st_reg.locked) begin
            st_next.out_buf_on = avs_writedata[READ_OUT_BUFFER_ON_BIT];
            st_next.inval_off = avs_writedata[CACHE_AUTO_INVAL_OFF_BIT];
         end else if ((avs_address == OFS_WRITE_CONTROL) && !st_reg.locked) begin
            st_next.pages = avs_writedata[PAGES_TO_ERASE_LSB +: 8];
            st_next.low_current = avs_writedata[LOW_CURRENT_PROGRAM_BIT];
            st_next.erase_irq_stop = avs_writedata[ERASE_STOP_ON_IRQ_BIT];
            st_next.wr_enable = avs_writedata[PROGRAM_ERASE_ENABLE_BIT];
         end else if (avs_address == OFS_WRITE_COMMAND) begin
            // Stop commands act even while busy
            if (avs_writedata[ERASE_STOP_CMD_BIT] && (st_reg.state != FS_IDLE) &&
                (st_reg.op != OP_PROGRAM)) begin
               st_next.op_abort = 1'b1;
               st_next.state = FS_IDLE;
            end
            if (avs_writedata[PROGRAM_STOP_CMD_BIT] && (st_reg.state != FS_IDLE) &&
                (st_reg.op == OP_PROGRAM)) begin
               st_next.op_abort = 1'b1;
               st_next.state = FS_IDLE;
            end
            if (avs_writedata[RESET_WORD_BUFFER_CMD_BIT]) begin
               st_next.word_free = 1'b1;
               st_next.word_loaded = 1'b0;
            end
            // Start commands; ignored while pending or busy
            if (idle_free) begin
               if (avs_writedata[MASS_ERASE_CMD_BIT]) begin
                  new_op = OP_MASS_ERASE;
               end else if (avs_writedata[MULTI_PAGE_ERASE_CMD_BIT]) begin
                  new_op = OP_RANGE_ERASE;
               end else if (avs_writedata[SINGLE_PAGE_ERASE_CMD_BIT]) begin
                  new_op = OP_PAGE_ERASE;
               end
            end
         end else if (avs_address == OFS_TARGET_ADDRESS_BUFFER) begin
            st_next.addr = avs_writedata;
            st_next.bad_addr = (avs_writedata > FLASH_ADDR_LIMIT);
         end else if (avs_address == OFS_PROGRAM_WORD_BUFFER) begin
            st_next.word = avs_writedata;
            st_next.word_loaded = 1'b1;
            st_next.word_free = 1'b0;
         end else if (avs_address == OFS_CONFIG_KEY) begin
            st_next.locked = (avs_writedata[15:0] != CONFIG_UNLOCK_CODE);
         end else if (avs_address == OFS_MASS_ERASE_GUARD) begin
            if (avs_writedata[MASS_ERASE_GUARD_BIT]) begin
               st_next.guard = 1'b1;
            end else if (root_access) begin
               st_next.guard = 1'b0;
            end
         end
      end

      // Security engine may start a mass erase regardless of guard
      if (se_mass_erase && idle_free && (new_op == OP_NONE)) begin
         new_op = OP_MASS_ERASE;
      end

      // A loaded word starts programming when nothing else was asked
      if ((new_op == OP_NONE) && idle_free && st_reg.word_loaded && st_reg.wr_enable &&
          !(wr_hit && (avs_address == OFS_WRITE_COMMAND))) begin
         new_op = OP_PROGRAM;
      end

      // Command acceptance checks
      if (new_op != OP_NONE) begin
         if (!st_reg.write_ready) begin
            st_next.refused = 1'b1;
         end else if ((new_op == OP_MASS_ERASE) && st_reg.guard && !se_mass_erase) begin
            st_next.refused = 1'b1;
         end else if ((new_op != OP_MASS_ERASE) && !st_reg.wr_enable) begin
            st_next.refused = 1'b1;
         end else begin
            st_next.refused = 1'b0;
            st_next.op = new_op;
            st_next.state = FS_PEND;
            if (new_op == OP_PROGRAM) begin
               st_next.timeout = 1'b0;
               st_next.word_loaded = 1'b0;
            end else begin
               st_next.erase_stopped = 1'b0;
            end
            if (new_op == OP_RANGE_ERASE) begin
               st_next.range_skipped = 1'b0;
            end
         end
      end

      // Sequencer
      case (st_reg.state)
         FS_IDLE: begin
         end
         FS_PEND: begin
            // Launch the queued operation
            if (st_next.state == FS_PEND) begin
               st_next.op_start = 1'b1;
               st_next.state = FS_RUN;
               if (((st_reg.op == OP_PROGRAM) || (st_reg.op == OP_PAGE_ERASE)) &&
                   !st_reg.inval_off) begin
                  st_next.inval = 1'b1;
               end
            end
         end
         FS_RUN: begin
            if (st_next.state == FS_RUN) begin
               if ((st_reg.op == OP_PAGE_ERASE) && st_reg.erase_irq_stop && cpu_irq) begin
                  st_next.op_abort = 1'b1;
                  st_next.erase_stopped = 1'b1;
                  st_next.state = FS_IDLE;
               end else if (flash_op_done) begin
                  st_next.state = FS_IDLE;
                  if (st_reg.op == OP_PROGRAM) begin
                     st_next.word_free = 1'b1;
                  end
               end
            end
         end
         default: begin
            st_next.state = FS_IDLE;
         end
      endcase

      // Hardware flags set last so a same-cycle clear loses
      if (flash_write_timeout) begin
         st_next.timeout = 1'b1;
      end
      if (flash_range_skipped) begin
         st_next.range_skipped = 1'b1;
      end
   end

   // ==========================================================
   // Registers
   // Loads reset values, otherwise takes the next state
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st_reg <= '0;
         st_reg.wait_n <= 1'b1;
         st_reg.read_mode <= READ_MODE_RESET;
         st_reg.out_buf_on <= READ_OUT_BUFFER_ON_RESET;
         st_reg.word_free <= WORD_FREE_RESET;
         st_reg.guard <= MASS_ERASE_GUARD_RESET;
         st_reg.write_ready <= WRITE_READY_RESET;
         st_reg.state <= FS_IDLE;
         st_reg.op <= OP_NONE;
      end else begin
         st_reg <= st_next;
      end
   end

   // ==========================================================
   // Outputs straight from the state
   assign avs_readdata = st_reg.rdata;
   assign avs_waitrequest = st_reg.wait_n;
   assign flash_op_start = st_reg.op_start;
   assign flash_op_kind = st_reg.op;
   assign flash_op_addr = st_reg.addr;
   assign flash_op_data = st_reg.word;
   assign flash_op_pages = st_reg.pages;
   assign flash_op_abort = st_reg.op_abort;
   assign flash_low_current = st_reg.low_current;
   assign flash_wait_states = st_reg.read_mode;
   assign flash_out_buf_en = st_reg.out_buf_on;
   assign cache_invalidate = st_reg.inval;
   assign dma_req = st_reg.word_free;

endmodule : fwec_ctrl

// file: fwec_ctrl_chk.sv
// Checker: bus and sequencer assertions for the flash sequencer
`timescale 1ns/100ps
module fwec_ctrl_chk
   import fwec_pkg::*;
(
   input wire logic core_clk, // Clock
   input wire logic sys_rst, // Reset
   input wire logic [11:0] avs_address, // Address
   input wire logic avs_read, // Read
   input wire logic avs_write, // Write
   input wire logic [31:0] avs_writedata, // Write data
   input wire logic [31:0] avs_readdata, // Read data
   input wire logic avs_waitrequest, // Stall
   input wire logic flash_op_done, // Op done
   input wire logic flash_op_start, // Op start
   input wire logic [2:0] flash_op_kind, // Op kind
   input wire logic [31:0] flash_op_addr, // Op address
   input wire logic [31:0] flash_op_data, // Op word
   input wire logic flash_op_abort, // Op abort
   input wire logic cache_invalidate, // Invalidate
   input wire logic dma_req // Word free
);
   default clocking dc @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);
   // ==========================================================
   // Helper: write taken, command write, running op, buffer shadows
   logic tk, cw, run_reg;
   logic [31:0] adr_reg, wd_reg;
   assign tk = avs_write && avs_waitrequest;
   assign cw = tk && (avs_address == OFS_WRITE_COMMAND);
   // Shadows follow taken writes; run follows start until done or abort
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         run_reg <= 1'h0;
         adr_reg <= ZERO_WORD;
         wd_reg <= ZERO_WORD;
      end else begin
         run_reg <= flash_op_start || (run_reg && !flash_op_done && !flash_op_abort);
         if (tk && avs_address == OFS_TARGET_ADDRESS_BUFFER) adr_reg <= avs_writedata;
         if (tk && avs_address == OFS_PROGRAM_WORD_BUFFER) wd_reg <= avs_writedata;
      end
   end
   // ==========================================================
   // Assertions
   a_cmd_reads_zero: assert property (avs_read && avs_waitrequest &&
      avs_address == OFS_WRITE_COMMAND |=> avs_readdata == ZERO_WORD) else $error("cmd read");
   a_clear_sets_free: assert property (cw && avs_writedata[12] |-> ##[1:2] dma_req)
      else $error("clear word");
   a_word_takes_free: assert property (tk && avs_address == OFS_PROGRAM_WORD_BUFFER |=> !dma_req)
      else $error("word free");
   a_erase_stop_aborts: assert property (cw && avs_writedata[5] && run_reg &&
      flash_op_kind > 3'h1 |=> flash_op_abort) else $error("erase stop");
   a_prog_stop_aborts: assert property (cw && avs_writedata[2] && run_reg &&
      flash_op_kind == 3'h1 |=> flash_op_abort) else $error("program stop");
   a_busy_no_start: assert property (run_reg |-> !flash_op_start) else $error("start busy");
   a_inval_with_start: assert property (cache_invalidate |-> flash_op_start &&
      (flash_op_kind == 3'h1 || flash_op_kind == 3'h2)) else $error("invalidate");
   a_addr_from_buf: assert property (flash_op_start |-> flash_op_addr == adr_reg)
      else $error("address");
   a_word_whole: assert property (flash_op_start && flash_op_kind == 3'h1 |->
      flash_op_data == wd_reg) else $error("word");
   // Main scenarios reached
   c_abort: cover property (flash_op_abort);
   c_inval: cover property (cache_invalidate);
   c_range: cover property (flash_op_start && flash_op_kind == 3'h3);
endmodule : fwec_ctrl_chk

bind fwec_ctrl fwec_ctrl_chk chk_u (.*);

// file: fwec_ctrl_tb_top.sv
// Testbench: bus-driven scenarios for the flash sequencer
`timescale 1ns/100ps
`define CHK(a,b) begin cmp_count++; if ((a)!==(b)) begin bad_count++; \
$display("[ERR] %0t got %h exp %h", $time, a, b); end end
module fwec_ctrl_tb_top
   import fwec_pkg::*;
;
   // ==========================================================
   // Stimulus and observed signals
   logic core_clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0, cpu_irq = 0;
   logic flash_op_done = 0, flash_write_timeout = 0, flash_range_skipped = 0;
   logic flash_pattern_fail = 0, flash_powered = 1, flash_write_ready = 1;
   logic se_mass_erase = 0, root_access = 0;
   logic [11:0] avs_address = '0;
   logic [31:0] avs_writedata = '0, rq, avs_readdata, flash_op_addr, flash_op_data;
   logic avs_waitrequest, flash_op_start, flash_op_abort, flash_low_current;
   logic flash_out_buf_en, cache_invalidate, dma_req;
   logic [2:0] flash_op_kind;
   logic [7:0] flash_op_pages;
   logic [1:0] flash_wait_states;
   int bad_count = 0, cmp_count = 0, cyc = 0;
   fwec_ctrl dut_u (.*);
   always #12.5 core_clk = ~core_clk;
   // Hang guard
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         bad_count++;
         $display("[ERR] %0t timeout", $time);
         test_done;
      end
   end
   // ==========================================================
   // Bus access: hold request until waitrequest low at a rising edge
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      @(posedge core_clk);
      while (avs_waitrequest !== 1'h0) begin
         @(posedge core_clk);
      end
      rq = avs_readdata;
      avs_read <= 1'h0;
      avs_write <= 1'h0;
   endtask : xfer
   task wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'h1, a, d);
   endtask : wr
   task rd(input logic [11:0] a, input logic [31:0] e);
      xfer(1'h0, a, ZERO_WORD);
      `CHK(rq, e)
   endtask : rd
   // Wait bounded for a start (0) or abort (1) pulse
   task wev(input logic ab);
      int n;
      n = 0;
      while ((ab ? flash_op_abort : flash_op_start) !== 1'h1 && n < 20) begin
         n++;
         @(posedge core_clk);
      end
      `CHK(n < 20, 1'h1)
   endtask : wev
   // One-cycle pulses on the security engine and array side inputs
   task pulse(input logic [4:0] m);
      @(posedge core_clk);
      {se_mass_erase, flash_pattern_fail, flash_range_skipped, flash_write_timeout,
         flash_op_done} <= m;
      @(posedge core_clk);
      {se_mass_erase, flash_pattern_fail, flash_range_skipped, flash_write_timeout,
         flash_op_done} <= 5'h00;
   endtask : pulse
   task tend(input string s);
      $display("test %s finished", s);
   endtask : tend
   task test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : test_done
   // ==========================================================
   // Main sequence
   initial begin
      repeat (4) @(posedge core_clk);
      sys_rst <= 1'h0;
      rd(OFS_CONTROLLER_STATUS, 32'h0900_0008);
      rd(OFS_READ_DATA_CONTROL, 32'h0000_1000);
      rd(OFS_READ_CONTROL, 32'h0020_0000);
      rd(OFS_WRITE_COMMAND, ZERO_WORD);
      rd(12'h100, ZERO_WORD);
      wr(OFS_MASS_ERASE_GUARD, ZERO_WORD);
      rd(OFS_MASS_ERASE_GUARD, 32'h0000_0001);
      tend("reset");
      for (int i = 0; i < 4; i++) begin
         wr(OFS_READ_CONTROL, 32'(i) << READ_MODE_LSB);
         @(negedge core_clk);
         `CHK(flash_wait_states, 2'(i))
      end
      wr(OFS_READ_DATA_CONTROL, ZERO_WORD);
      @(negedge core_clk);
      `CHK(flash_out_buf_en, 1'h0)
      wr(OFS_CONFIG_KEY, ZERO_WORD);
      rd(OFS_CONFIG_KEY, 32'h0000_0001);
      rd(OFS_CONTROLLER_STATUS, 32'h0901_0008);
      wr(OFS_READ_CONTROL, ZERO_WORD);
      @(negedge core_clk);
      `CHK(flash_wait_states, 2'h3)
      wr(OFS_CONFIG_KEY, {16'h0000, CONFIG_UNLOCK_CODE});
      tend("config");
      wr(OFS_WRITE_COMMAND, 32'h0000_0100);
      rd(OFS_CONTROLLER_STATUS, 32'h0900_000a);
      pulse(5'h10);
      wev(1'h0);
      `CHK(flash_op_kind, 3'h4)
      wr(OFS_WRITE_COMMAND, 32'h0000_0020);
      wev(1'h1);
      tend("mass");
      wr(OFS_WRITE_CONTROL, 32'h0000_000b);
      wr(OFS_TARGET_ADDRESS_BUFFER, 32'h0000_1000);
      wr(OFS_WRITE_COMMAND, 32'h0000_0002);
      wev(1'h0);
      `CHK(flash_op_addr, 32'h0000_1000)
      `CHK({flash_low_current, cache_invalidate}, 2'h3)
      rd(OFS_CONTROLLER_STATUS, 32'h0900_0009);
      cpu_irq <= 1'h1;
      wev(1'h1);
      cpu_irq <= 1'h0;
      rd(OFS_CONTROLLER_STATUS, 32'h0900_0018);
      wr(OFS_WRITE_CONTROL, ZERO_WORD);
      wr(OFS_WRITE_COMMAND, 32'h0000_0002);
      rd(OFS_CONTROLLER_STATUS, 32'h0900_001a);
      tend("page");
      wr(OFS_WRITE_CONTROL, 32'h0005_0001);
      wr(OFS_TARGET_ADDRESS_BUFFER, 32'h8000_2000);
      wr(OFS_WRITE_COMMAND, 32'h0000_0010);
      wev(1'h0);
      `CHK({flash_op_kind, flash_op_pages}, 11'h305)
      `CHK(flash_op_addr, 32'h8000_2000)
      pulse(5'h01);
      tend("range");
      wr(OFS_PROGRAM_WORD_BUFFER, 32'ha5a5_5a5a);
      @(negedge core_clk);
      `CHK(dma_req, 1'h0)
      wev(1'h0);
      `CHK({flash_op_kind, flash_op_data}, 35'h1_a5a5_5a5a)
      wr(OFS_WRITE_COMMAND, 32'h0000_0004);
      wev(1'h1);
      wr(OFS_WRITE_COMMAND, 32'h0000_1000);
      @(negedge core_clk);
      `CHK(dma_req, 1'h1)
      tend("program");
      pulse(5'h0e);
      pulse(5'h08);
      rd(OFS_CONTROLLER_STATUS, 32'h2900_00cc);
      flash_powered <= 1'h0;
      repeat (2) @(posedge core_clk);
      rd(OFS_CONTROLLER_STATUS, 32'h2800_00cc);
      tend("flags");
      test_done;
   end
endmodule : fwec_ctrl_tb_top
